/* rtl/srw_supervisor.sv */
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module srw_supervisor #(
  parameter logic [2:0] THR_B_RST = srw_pkg::SRW_THR_B_RST,
  parameter int TICK_CYCLES = srw_pkg::SRW_TICK_CYCLES
) (
  // AHB-Lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Monitor flags and requests
  input wire logic low_rail_monitor_a,
  input wire logic low_rail_monitor_b,
  input wire logic hv_shutdown_req,
  // Processor side
  input wire logic watchdog_strobe_in,
  input wire logic watchdog_float_in,
  input wire logic manual_reset_in_n,
  // Supervisory outputs
  output logic reset_out,
  output logic shutdown_out_n,
  output logic comparator_status_out,
  output logic shutdown_rail_sel,
  output logic [2:0] threshold_a_code,
  output logic [2:0] threshold_b_code
);
  import srw_pkg::*;

  // ----------------------------------------------------------------
  // Timebase and hold timers
  // ----------------------------------------------------------------
  logic tick;
  srw_time_if rst_t ();
  srw_time_if sd_t ();

  // One fixed tick drives every interval
  srw_tick #(.DIV(TICK_CYCLES)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  srw_hold_timer u_rst_hold (
    .hclk(hclk),
    .hresetn(hresetn),
    .t(rst_t.tmr)
  );

  srw_hold_timer u_sd_hold (
    .hclk(hclk),
    .hresetn(hresetn),
    .t(sd_t.tmr)
  );

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic aph_q;
  logic wr_q;
  logic [7:0] idx_q;
  wire logic take = hsel & htrans[1] & hready;

  // Only whole words are used, so hsize is not decoded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q <= 1'b0;
      wr_q <= 1'b0;
      idx_q <= 8'h00;
    end else begin
      aph_q <= take;
      wr_q <= hwrite;
      idx_q <= haddr[9:2];
    end
  end

  // Write strobes per register
  wire logic wr_en = aph_q & wr_q;
  wire logic wr_thr_a = wr_en & (idx_q == SRW_IDX_THR_A);
  wire logic wr_thr_b = wr_en & (idx_q == SRW_IDX_THR_B);
  wire logic wr_hold = wr_en & (idx_q == SRW_IDX_HOLD);
  wire logic wr_rcfg = wr_en & (idx_q == SRW_IDX_RCFG);
  wire logic wr_rail = wr_en & (idx_q == SRW_IDX_RAIL);
  wire logic wr_wdcfg = wr_en & (idx_q == SRW_IDX_WDCFG);
  wire logic wr_swsd = wr_en & (idx_q == SRW_IDX_SWSD);
  wire logic wr_swen = wr_en & (idx_q == SRW_IDX_SWEN);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [2:0] thr_a_q;
  logic [2:0] thr_b_q;
  logic [6:0] hold_q;
  logic [3:0] rcfg_q;
  logic rail_q;
  logic [3:0] wdcfg_q;
  logic swsd_q;
  logic swen_n_q;

  // Threshold codes, one register per monitor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thr_a_q <= SRW_THR_A_RST;
      thr_b_q <= THR_B_RST;
    end else begin
      if (wr_thr_a) thr_a_q <= hwdata[2:0];
      if (wr_thr_b) thr_b_q <= hwdata[2:0];
    end
  end

  // Timing and mode controls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_q <= SRW_HOLD_RST;
      rcfg_q <= SRW_RCFG_RST;
      rail_q <= 1'b0;
      wdcfg_q <= SRW_WDCFG_RST;
    end else begin
      if (wr_hold) hold_q <= hwdata[6:0];
      if (wr_rcfg) rcfg_q <= hwdata[3:0];
      if (wr_rail) rail_q <= hwdata[SRW_RAIL_SEL];
      if (wr_wdcfg) wdcfg_q <= hwdata[3:0];
    end
  end

  // Software shutdown request and its enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      swsd_q <= 1'b0;
      swen_n_q <= SRW_SWEN_N_RST;
    end else begin
      if (wr_swsd) swsd_q <= hwdata[SRW_SWSD_BIT];
      if (wr_swen) swen_n_q <= hwdata[SRW_SWEN_BIT];
    end
  end

  // Field decode
  wire logic pol_high = rcfg_q[SRW_RCFG_POL];
  wire logic b_dis = rcfg_q[SRW_RCFG_BDIS];
  wire logic flt_en = rcfg_q[SRW_RCFG_FLT];
  wire logic wd_adv = wdcfg_q[SRW_WD_MODE];
  wire logic [SRW_CNT_W-1:0] rst_hold_len = SRW_HOLD_TICKS[hold_q[2:0]];
  wire logic [SRW_CNT_W-1:0] sd_hold_len = SRW_HOLD_TICKS[hold_q[SRW_HOLD_SD_LSB +: 3]];
  wire logic [SRW_CNT_W-1:0] wd_len = SRW_WD_TICKS[wdcfg_q[2:0]];

  // ----------------------------------------------------------------
  // Power-up and manual reset
  // ----------------------------------------------------------------
  logic pwr_q;
  logic [SRW_CNT_W-1:0] mr_cnt_q;
  logic mr_act_q;
  wire logic mr_low = ~manual_reset_in_n;

  // Power-up counts as a trigger for both hold timers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_q <= 1'b1;
    end else begin
      pwr_q <= 1'b0;
    end
  end

  // Manual reset delay, restarted whenever the input goes high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mr_cnt_q <= '0;
      mr_act_q <= 1'b0;
    end else if (!mr_low) begin
      mr_cnt_q <= '0;
      mr_act_q <= 1'b0;
    end else if (tick && !mr_act_q) begin
      mr_cnt_q <= mr_cnt_q + 1'b1;
      mr_act_q <= (mr_cnt_q + 1'b1 >= SRW_MR_TICKS);
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic strobe_q;
  logic [SRW_CNT_W-1:0] wd_cnt_q;
  logic [1:0] fails_q;
  logic wd_pulse_q;
  logic [SRW_CNT_W-1:0] wd_sd_cnt_q;
  logic rst_active;
  wire logic strobe_edge = watchdog_strobe_in ^ strobe_q;
  wire logic wd_expire = tick & (wd_cnt_q + 1'b1 >= wd_len);
  wire logic wd_sd_act = (wd_sd_cnt_q != '0);
  wire logic wd_fourth = wd_adv & (fails_q == SRW_WD_TRIES);

  // Timeout counter, idle while reset is shown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_q <= 1'b0;
      wd_cnt_q <= '0;
      wd_pulse_q <= 1'b0;
    end else begin
      strobe_q <= watchdog_strobe_in;
      wd_pulse_q <= 1'b0;
      if (rst_active || strobe_edge) begin
        wd_cnt_q <= '0;
      end else if (wd_expire) begin
        wd_cnt_q <= '0;
        wd_pulse_q <= 1'b1;
      end else if (tick) begin
        wd_cnt_q <= wd_cnt_q + 1'b1;
      end
    end
  end

  // Missed-timeout tally; survives reset pulses, cleared by an edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fails_q <= 2'h0;
    end else if (strobe_edge || !wd_adv) begin
      fails_q <= 2'h0;
    end else if (wd_pulse_q) begin
      fails_q <= wd_fourth ? 2'h0 : fails_q + 2'h1;
    end
  end

  // One second shutdown beside the fourth pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_sd_cnt_q <= '0;
    end else if (wd_pulse_q && wd_fourth) begin
      wd_sd_cnt_q <= SRW_WD_SD_TICKS;
    end else if (tick && wd_sd_act) begin
      wd_sd_cnt_q <= wd_sd_cnt_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Trigger combination
  // ----------------------------------------------------------------
  wire logic b_trig = low_rail_monitor_b & ~b_dis;
  wire logic flt_trig = watchdog_float_in & flt_en;
  wire logic sw_sd = swsd_q & ~swen_n_q;
  wire logic sd_active = sd_t.active;

  // Manual reset first: it overrides the floating and watchdog paths
  wire logic rst_trig = mr_act_q | mr_low | pwr_q | low_rail_monitor_a | b_trig |
    (~mr_low & (flt_trig | wd_pulse_q));

  // Shutdown sources, released through the shutdown hold timer
  wire logic sd_trig = pwr_q | hv_shutdown_req | wd_sd_act | sw_sd;

  // Manual input low before its delay is kept out of the output path
  logic rst_seen_q;
  wire logic rst_hold_busy = rst_t.active & ~(mr_low & ~mr_act_q & ~rst_seen_q);

  assign rst_t.tick = tick;
  assign rst_t.trig = rst_trig & ~(mr_low & ~mr_act_q);
  assign rst_t.limit = rst_hold_len;
  assign sd_t.tick = tick;
  assign sd_t.trig = sd_trig;
  assign sd_t.limit = sd_hold_len;

  // Shutdown drags reset along on its own timing
  assign rst_active = rst_hold_busy | sd_active;

  // Remembers that reset was already shown when the manual input fell
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_seen_q <= 1'b1;
    end else if (!mr_low) begin
      rst_seen_q <= rst_t.active;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic reset_out_q;
  logic shutdown_n_q;
  logic cmp_q;

  // Polarity applied at the pin; power-up shows reset active
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_out_q <= 1'b0;
      shutdown_n_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      reset_out_q <= pol_high ? rst_active : ~rst_active;
      shutdown_n_q <= ~sd_active;
      cmp_q <= low_rail_monitor_b;
    end
  end

  assign reset_out = reset_out_q;
  assign shutdown_out_n = shutdown_n_q;
  assign comparator_status_out = cmp_q;
  assign shutdown_rail_sel = rail_q;
  assign threshold_a_code = thr_a_q;
  assign threshold_b_code = thr_b_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  wire logic [7:0] rd_idx = haddr[9:2];
  wire logic [31:0] stat_word = {25'h0, wd_sd_act, fails_q, low_rail_monitor_a,
    low_rail_monitor_b, sd_active, rst_active};

  // Unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rd_idx)
      SRW_IDX_THR_A: rd_mux = {29'h0, thr_a_q};
      SRW_IDX_THR_B: rd_mux = {29'h0, thr_b_q};
      SRW_IDX_HOLD: rd_mux = {25'h0, hold_q};
      SRW_IDX_RCFG: rd_mux = {28'h0, rcfg_q};
      SRW_IDX_RAIL: rd_mux = {28'h0, rail_q, 3'h0};
      SRW_IDX_WDCFG: rd_mux = {28'h0, wdcfg_q};
      SRW_IDX_SWSD: rd_mux = {29'h0, swsd_q, 2'h0};
      SRW_IDX_SWEN: rd_mux = {27'h0, swen_n_q, 4'h0};
      SRW_IDX_STAT: rd_mux = stat_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data sampled at the address phase; zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      rdata_q <= rd_mux;
    end
  end

  logic ready_q;
  logic resp_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = ready_q;
  assign hresp = resp_q;
endmodule : srw_supervisor
`default_nettype wire

/* rtl/srw_pkg.sv */
package srw_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int SRW_CLK_MHZ = 200;
  localparam int SRW_TICK_US = 10;
  localparam int SRW_TICK_CYCLES = SRW_CLK_MHZ * SRW_TICK_US;
  localparam int SRW_CNT_W = 18;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] SRW_IDX_THR_A = 8'h05;
  localparam logic [7:0] SRW_IDX_THR_B = 8'h06;
  localparam logic [7:0] SRW_IDX_HOLD = 8'h08;
  localparam logic [7:0] SRW_IDX_RCFG = 8'h0D;
  localparam logic [7:0] SRW_IDX_RAIL = 8'h0E;
  localparam logic [7:0] SRW_IDX_WDCFG = 8'h0F;
  localparam logic [7:0] SRW_IDX_SWSD = 8'h16;
  localparam logic [7:0] SRW_IDX_SWEN = 8'h18;
  localparam logic [7:0] SRW_IDX_STAT = 8'h1A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SRW_RCFG_POL = 1;
  localparam int SRW_RCFG_BDIS = 2;
  localparam int SRW_RCFG_FLT = 3;
  localparam int SRW_RAIL_SEL = 3;
  localparam int SRW_WD_MODE = 3;
  localparam int SRW_SWSD_BIT = 2;
  localparam int SRW_SWEN_BIT = 4;
  localparam int SRW_HOLD_SD_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] SRW_THR_A_RST = 3'h0;
  localparam logic [2:0] SRW_THR_B_RST = 3'h6;
  localparam logic [6:0] SRW_HOLD_RST = 7'h22;
  localparam logic [3:0] SRW_RCFG_RST = 4'h4;
  localparam logic [3:0] SRW_WDCFG_RST = 4'h6;
  localparam logic SRW_SWEN_N_RST = 1'b1;

  // ----------------------------------------------------------------
  // Timing in ticks of the internal timebase
  // ----------------------------------------------------------------
  localparam logic [SRW_CNT_W-1:0] SRW_HOLD_TICKS [8] = '{
    18'h0000A, 18'h00064, 18'h003E8, 18'h007D0,
    18'h01388, 18'h02710, 18'h03A98, 18'h04E20};
  localparam logic [SRW_CNT_W-1:0] SRW_WD_TICKS [8] = '{
    18'h02710, 18'h04E20, 18'h09C40, 18'h0EA60,
    18'h13880, 18'h186A0, 18'h249F0, 18'h30D40};
  localparam int SRW_WD_SD_MS = 1000;
  localparam logic [SRW_CNT_W-1:0] SRW_WD_SD_TICKS = SRW_CNT_W'(SRW_WD_SD_MS * 1000 / SRW_TICK_US);
  localparam int SRW_MR_DELAY_US = 1000;
  localparam logic [SRW_CNT_W-1:0] SRW_MR_TICKS = SRW_CNT_W'(SRW_MR_DELAY_US / SRW_TICK_US);
  localparam logic [1:0] SRW_WD_TRIES = 2'h3;

endpackage : srw_pkg

/* rtl/srw_time_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Hold timer link: trigger level, reload length, tick and busy state
interface srw_time_if;
  import srw_pkg::*;
  logic tick;
  logic trig;
  logic [SRW_CNT_W-1:0] limit;
  logic active;
  modport ctl (output tick, output trig, output limit, input active);
  modport tmr (input tick, input trig, input limit, output active);
endinterface : srw_time_if
`default_nettype wire

/* rtl/srw_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module srw_tick #(
  parameter int DIV = srw_pkg::SRW_TICK_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Timebase pulse
  output logic tick
);
  import srw_pkg::*;

  logic [15:0] div_q;
  logic tick_q;
  wire logic wrap = (div_q == 16'(DIV - 1));

  // Free-running divider, one-cycle pulse per tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      div_q <= wrap ? 16'h0000 : div_q + 16'h0001;
      tick_q <= wrap;
    end
  end

  assign tick = tick_q;
endmodule : srw_tick
`default_nettype wire

/* rtl/srw_hold_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module srw_hold_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control link
  srw_time_if.tmr t
);
  import srw_pkg::*;

  logic [SRW_CNT_W-1:0] cnt_q;
  logic [SRW_CNT_W-1:0] cnt_d;
  wire logic running = (cnt_q != '0);

  // Any trigger reloads, so release always follows a full hold
  assign cnt_d = t.trig ? t.limit : (t.tick && running) ? cnt_q - 1'b1 : cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign t.active = t.trig | running;
endmodule : srw_hold_timer
`default_nettype wire

/* bench/srw_supervisor_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module srw_supervisor_sva #(
  parameter int TICK_CYCLES = 2000
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Monitors and processor side
  input wire logic low_rail_monitor_a,
  input wire logic low_rail_monitor_b,
  input wire logic hv_shutdown_req,
  input wire logic watchdog_strobe_in,
  input wire logic watchdog_float_in,
  input wire logic manual_reset_in_n,
  // Outputs
  input wire logic reset_out,
  input wire logic shutdown_out_n,
  input wire logic comparator_status_out,
  input wire logic shutdown_rail_sel,
  input wire logic [2:0] threshold_a_code,
  input wire logic [2:0] threshold_b_code
);
  import srw_pkg::*;
  // --------------------
  // Helper state
  // --------------------
  // Manual delay plus output latency and two ticks of jitter
  localparam int MR_LIM = (SRW_MR_DELAY_US / SRW_TICK_US + 2) * TICK_CYCLES + 4;
  logic aw_q;
  logic [31:0] aa_q;
  logic pol_q;
  logic swen_q;
  logic swsd_q;
  int mr_cnt_q;
  wire logic [7:0] widx = aa_q[9:2];
  wire logic wr_now = aw_q && hready;
  wire logic act = (reset_out == pol_q);
  // Address phase of a write, kept for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_q <= 1'b0;
      aa_q <= 32'h0;
    end else if (hready) begin
      aw_q <= hsel && htrans[1] && hwrite;
      aa_q <= haddr;
    end
  end
  // Shadow of the bits that change how outputs read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pol_q <= 1'b0;
      swen_q <= 1'b1;
      swsd_q <= 1'b0;
    end else if (wr_now) begin
      if (widx == SRW_IDX_RCFG) pol_q <= hwdata[SRW_RCFG_POL];
      if (widx == SRW_IDX_SWEN) swen_q <= hwdata[SRW_SWEN_BIT];
      if (widx == SRW_IDX_SWSD) swsd_q <= hwdata[SRW_SWSD_BIT];
    end
  end
  // Length of the present manual press, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) mr_cnt_q <= 0;
    else if (manual_reset_in_n) mr_cnt_q <= 0;
    else if (mr_cnt_q < 1000000) mr_cnt_q <= mr_cnt_q + 1;
  end
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_status_copy: assert property (
    comparator_status_out == $past(low_rail_monitor_b)) else $error("status not monitor b");
  a_thr_a_write: assert property (
    wr_now && widx == SRW_IDX_THR_A |=> threshold_a_code == $past(hwdata[2:0]))
    else $error("threshold a not stored");
  a_thr_b_write: assert property (
    wr_now && widx == SRW_IDX_THR_B |=> threshold_b_code == $past(hwdata[2:0]))
    else $error("threshold b not stored");
  a_mon_a_reset: assert property (
    low_rail_monitor_a ##1 low_rail_monitor_a |=> act) else $error("no reset on monitor a");
  a_hold_min: assert property (
    $past(low_rail_monitor_a, 2) && !low_rail_monitor_a |-> act [*8])
    else $error("reset released before hold");
  a_manual_wins: assert property (
    mr_cnt_q > MR_LIM |-> act) else $error("manual press without reset");
  a_sw_shut: assert property (
    (!swen_q && swsd_q) [*3] |=> !shutdown_out_n) else $error("software shutdown missing");
  a_hv_shut: assert property (
    hv_shutdown_req [*2] |=> !shutdown_out_n) else $error("fault shutdown missing");
  a_reset_follows: assert property (
    !shutdown_out_n [*2] |-> act) else $error("reset not following shutdown");
  a_sd_hold: assert property (
    $rose(shutdown_out_n) |-> !$past(hv_shutdown_req, 8)) else $error("shutdown hold short");
  // Main scenarios reached
  c_manual: cover property (mr_cnt_q == MR_LIM);
  c_sw: cover property (!swen_q && swsd_q);
  c_wd_shut: cover property ($fell(shutdown_out_n) && !hv_shutdown_req && swen_q);
endmodule : srw_supervisor_sva
bind srw_supervisor srw_supervisor_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);
`default_nettype wire

/* bench/srw_proc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module srw_proc_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Service control; dropping en models a hung processor
  input wire logic en,
  input wire logic [15:0] period,
  // Strobe to the supervisor
  output logic strobe
);
  logic [15:0] cnt_q;
  // Toggle at once on enable, then once a period; either edge services
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0;
      strobe <= 1'b0;
    end else if (!en) begin
      cnt_q <= 16'h0;
    end else begin
      cnt_q <= (cnt_q >= period - 16'h1) ? 16'h0 : cnt_q + 16'h1;
      if (cnt_q == 16'h0) strobe <= ~strobe;
    end
  end
endmodule : srw_proc_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import srw_pkg::*;
  // --------------------
  // Signals
  // --------------------
  localparam int TICK = 1;
  localparam int WD_CYC = 10000 * TICK; // 100 ms in 10 us ticks
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic low_rail_monitor_a = 1'b0;
  logic low_rail_monitor_b = 1'b0;
  logic hv_shutdown_req = 1'b0;
  logic watchdog_float_in = 1'b0;
  logic manual_reset_in_n = 1'b1;
  logic proc_en = 1'b0;
  logic pol = 1'b0;
  int errors = 0;
  int comparisons = 0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, reset_out, shutdown_out_n, comparator_status_out;
  wire logic shutdown_rail_sel, watchdog_strobe_in;
  wire logic [2:0] threshold_a_code, threshold_b_code;
  // Free-running clock
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  // Short tick so long intervals fit the run; hsize is not decoded
  srw_supervisor #(.TICK_CYCLES(TICK)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .low_rail_monitor_a(low_rail_monitor_a), .low_rail_monitor_b(low_rail_monitor_b),
    .hv_shutdown_req(hv_shutdown_req), .watchdog_strobe_in(watchdog_strobe_in),
    .watchdog_float_in(watchdog_float_in), .manual_reset_in_n(manual_reset_in_n),
    .reset_out(reset_out), .shutdown_out_n(shutdown_out_n),
    .comparator_status_out(comparator_status_out), .shutdown_rail_sel(shutdown_rail_sel),
    .threshold_a_code(threshold_a_code), .threshold_b_code(threshold_b_code));
  srw_proc_model u_proc (.hclk(hclk), .hresetn(hresetn), .en(proc_en), .period(16'h03E8),
    .strobe(watchdog_strobe_in));
  // --------------------
  // Shared tasks
  // --------------------
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic clk(input int n);
    repeat (n) @(posedge hclk);
  endtask : clk
  // One single transfer; entered and left just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    chk("okay response", hresp, 0);
    if (n >= 50) begin errors++; tally_and_finish(); end
  endtask : ahb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, idx, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] r;
    ahb(1'b0, idx, 32'h0, r);
    chk(what, r, exp);
  endtask : rd
  function automatic logic act();
    return reset_out === pol;
  endfunction : act
  // Bounded waits on reset activity and on shutdown release
  task automatic wait_act(input logic lvl, input int bound, output int n);
    n = 0;
    while (act() !== lvl && n < bound) begin @(posedge hclk); n++; end
    if (n >= bound) begin errors++; tally_and_finish(); end
  endtask : wait_act
  task automatic wait_sd(output int n);
    n = 0;
    while (shutdown_out_n !== 1'b1 && n < 200) begin @(posedge hclk); n++; end
    if (n >= 200) begin errors++; tally_and_finish(); end
  endtask : wait_sd
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_power();
    int n;
    chk("power-up shutdown", shutdown_out_n, 0);
    wait_act(1'b0, 5000, n);
    chk("shutdown released", shutdown_out_n, 1);
    rd(SRW_IDX_THR_A, 32'h0, "thr a");
    rd(SRW_IDX_THR_B, 32'(SRW_THR_B_RST), "thr b");
    rd(SRW_IDX_RCFG, 32'h4, "rcfg");
    rd(SRW_IDX_WDCFG, 32'h6, "wdcfg");
    rd(SRW_IDX_SWEN, 32'h10, "swen");
    rd(8'h30, 32'h0, "unmapped");
    chk("rail default", shutdown_rail_sel, 0);
    wr(SRW_IDX_THR_A, 32'h5);
    wr(SRW_IDX_THR_B, 32'h3);
    wr(SRW_IDX_RAIL, 32'h8);
    clk(1);
    chk("thr a code", threshold_a_code, 5);
    chk("thr b code", threshold_b_code, 3);
    chk("rail select", shutdown_rail_sel, 1);
    wr(SRW_IDX_HOLD, 32'h0);
    $display("power-up and registers done");
  endtask : t_power
  task automatic t_monitors();
    int n;
    low_rail_monitor_a <= 1'b1;
    clk(4);
    chk("monitor a reset", act(), 1);
    low_rail_monitor_a <= 1'b0;
    clk(6);
    low_rail_monitor_a <= 1'b1;
    clk(1);
    low_rail_monitor_a <= 1'b0;
    wait_act(1'b0, 100, n);
    chk("hold restarted", n >= 9 * TICK && n <= 15 * TICK, 1);
    low_rail_monitor_b <= 1'b1;
    clk(3);
    chk("status b", comparator_status_out, 1);
    chk("monitor b blocked", act(), 0);
    wr(SRW_IDX_RCFG, 32'h0);
    clk(4);
    chk("monitor b reset", act(), 1);
    low_rail_monitor_b <= 1'b0;
    clk(2);
    chk("status b clear", comparator_status_out, 0);
    wait_act(1'b0, 100, n);
    watchdog_float_in <= 1'b1;
    clk(4);
    chk("float ignored", act(), 0);
    wr(SRW_IDX_RCFG, 32'hA);
    pol = 1'b1;
    clk(4);
    chk("float reset high", reset_out, 1);
    watchdog_float_in <= 1'b0;
    wait_act(1'b0, 100, n);
    chk("idle level high pol", reset_out, 0);
    wr(SRW_IDX_RCFG, 32'h4);
    pol = 1'b0;
    $display("monitor, float and polarity done");
  endtask : t_monitors
  task automatic t_manual();
    int n;
    manual_reset_in_n <= 1'b0;
    clk(90 * TICK);
    chk("manual delay", act(), 0);
    clk(20 * TICK);
    chk("manual reset", act(), 1);
    manual_reset_in_n <= 1'b1;
    wait_act(1'b0, 100, n);
    chk("manual hold", n >= 9 * TICK, 1);
    $display("manual reset done");
  endtask : t_manual
  task automatic t_shutdown();
    int n;
    hv_shutdown_req <= 1'b1;
    clk(4);
    chk("fault shutdown", shutdown_out_n, 0);
    hv_shutdown_req <= 1'b0;
    wait_sd(n);
    chk("fault hold", n >= 9 * TICK && n <= 16 * TICK, 1);
    wr(SRW_IDX_SWSD, 32'h4);
    clk(4);
    chk("sw blocked", shutdown_out_n, 1);
    wr(SRW_IDX_SWEN, 32'h0);
    clk(4);
    chk("sw shutdown", shutdown_out_n, 0);
    chk("reset follows", act(), 1);
    wr(SRW_IDX_SWSD, 32'h0);
    wait_sd(n);
    chk("sw hold", n >= 9 * TICK && n <= 16 * TICK, 1);
    wr(SRW_IDX_SWEN, 32'h10);
    wait_act(1'b0, 100, n);
    $display("shutdown done");
  endtask : t_shutdown
  task automatic t_watchdog();
    int n;
    proc_en <= 1'b1;
    wr(SRW_IDX_WDCFG, 32'h0);
    clk(WD_CYC + 2000);
    chk("serviced no reset", act(), 0);
    proc_en <= 1'b0;
    wait_act(1'b1, WD_CYC + 100, n);
    chk("first expiry", n >= WD_CYC - 1100, 1);
    wait_act(1'b0, 100, n);
    wait_act(1'b1, WD_CYC + 100, n);
    chk("repeat expiry", n >= WD_CYC - 10, 1);
    wait_act(1'b0, 100, n);
    proc_en <= 1'b1;
    wr(SRW_IDX_WDCFG, 32'h8);
    clk(1500);
    proc_en <= 1'b0;
    for (int k = 1; k <= 4; k++) begin
      wait_act(1'b1, WD_CYC + 2000, n);
      clk(3);
      chk("advanced shutdown", shutdown_out_n, 32'(k < 4));
      if (k < 4) wait_act(1'b0, 100, n);
    end
    $display("watchdog done");
  endtask : t_watchdog
  // Reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_power();
    t_monitors();
    t_manual();
    t_shutdown();
    t_watchdog();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
